// ---- src/fpi_pkg.sv ----
// package of constants and types for the front-panel indicator block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package fpi_pkg;

    // timing
    localparam int CLK_MHZ = 250;
    localparam int LIT_TIME_MS = 100;
    localparam int FAIL_TIME_S = 30;
    localparam longint LIT_CYCLES = longint'(LIT_TIME_MS) * CLK_MHZ * 1000;
    localparam longint FAIL_CYCLES = longint'(FAIL_TIME_S) * CLK_MHZ * 1000000;

    // register offsets
    localparam logic [3:0] ADDR_TRIG_CFG = 4'h0;
    localparam logic [3:0] ADDR_OUT_CTRL = 4'h1;
    localparam logic [3:0] ADDR_SYS_CTRL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;

    // trigger config field positions
    localparam int TC_POL_LSB = 0;
    localparam int TC_TRIG_EXT = 2;
    localparam int TC_EVT_EXT = 3;
    localparam int TC_GATED = 4;
    localparam int TC_SYNC = 5;
    localparam logic [7:0] TRIG_CFG_RESET = 8'h00;

    // sys ctrl field positions
    localparam int SC_OPT_LSB = 0;
    localparam int SC_MODE_LSB = 2;
    localparam int SC_INIT_DONE = 4;
    localparam int SC_SELFTEST_ERR = 5;

    typedef enum logic [1:0] {
        FPI_POL_RISE = 2'b00,
        FPI_POL_FALL = 2'b01,
        FPI_POL_EITHER = 2'b10
    } fpi_pol_t;

    typedef enum logic [1:0] {
        FPI_OPT_1CH = 2'b00,
        FPI_OPT_2CH = 2'b01,
        FPI_OPT_4CH = 2'b10
    } fpi_opt_t;

    typedef enum logic [1:0] {
        FPI_MODE_DUAL = 2'b00,
        FPI_MODE_DUAL_MRK = 2'b01,
        FPI_MODE_DUAL_DUP = 2'b10
    } fpi_mode_t;

    typedef enum logic [1:0] {
        FPI_LED_OFF = 2'b00,
        FPI_LED_GREEN = 2'b01,
        FPI_LED_RED = 2'b10
    } fpi_led_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpi_bus_t;

    // per input pin sample: level plus timing-violation flag
    typedef struct packed {
        logic level;
        logic violation;
    } fpi_pin_t;

endpackage : fpi_pkg

// ---- src/fpi_indicators.sv ----
// front-panel indicator logic: trigger/event, outputs, access and fail
`timescale 1ns/1ps
module fpi_indicators #(
    parameter longint LIT_CYC = fpi_pkg::LIT_CYCLES,
    parameter longint FAIL_CYC = fpi_pkg::FAIL_CYCLES,
    parameter int NUM_OUT = 4
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire fpi_pkg::fpi_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire fpi_pkg::fpi_pin_t trig_pin_i,
    input wire fpi_pkg::fpi_pin_t event_pin_i,
    input wire logic [NUM_OUT-1:0] term_fault_i,
    output fpi_pkg::fpi_led_t trig_led_o,
    output fpi_pkg::fpi_led_t event_led_o,
    output fpi_pkg::fpi_led_t [NUM_OUT-1:0] out_led_o,
    output logic [NUM_OUT-1:0] amp_power_o,
    output logic [NUM_OUT-1:0] analog_en_o,
    output logic [NUM_OUT-1:0] marker_en_o,
    output logic access_led_o,
    output logic fail_led_o
);
    import fpi_pkg::*;

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [7:0] trig_cfg_reg;
    logic [NUM_OUT-1:0] out_en_reg;
    logic [NUM_OUT-1:0] fault_reg;
    logic [5:0] sys_ctrl_reg;
    logic [7:0] trig_cfg_next;
    fpi_pol_t pol;
    logic gated;
    logic sync_mode;

    always_comb
    begin
        trig_cfg_next = bus_i.wdata;
        // gated mode cannot take the both-edges polarity
        if (bus_i.wdata[TC_GATED] &&
            bus_i.wdata[TC_POL_LSB +: 2] == FPI_POL_EITHER)
        begin
            trig_cfg_next[TC_POL_LSB +: 2] = FPI_POL_RISE;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            trig_cfg_reg <= TRIG_CFG_RESET;
        end
        else if (bus_i.wr && bus_i.addr == ADDR_TRIG_CFG)
        begin
            trig_cfg_reg <= trig_cfg_next;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            sys_ctrl_reg <= '0;
        end
        else if (bus_i.wr && bus_i.addr == ADDR_SYS_CTRL)
        begin
            sys_ctrl_reg <= bus_i.wdata[5:0];
        end
    end

    assign pol = fpi_pol_t'(trig_cfg_reg[TC_POL_LSB +: 2]);
    assign gated = trig_cfg_reg[TC_GATED];
    assign sync_mode = trig_cfg_reg[TC_SYNC];

    //------------------------------------------------------------------
    // output enables and protection
    //------------------------------------------------------------------
    // fault is sticky; cleared by software writing 1, set wins over clear
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            fault_reg <= '0;
        end
        else if (bus_i.wr && bus_i.addr == ADDR_STATUS)
        begin
            fault_reg <= (fault_reg & ~bus_i.wdata[NUM_OUT-1:0])
                | term_fault_i;
        end
        else
        begin
            fault_reg <= fault_reg | term_fault_i;
        end
    end

    // a fault drops the enable, so only an explicit re-enable restores it
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !sys_ctrl_reg[SC_INIT_DONE])
        begin
            out_en_reg <= '0;
        end
        else if (bus_i.wr && bus_i.addr == ADDR_OUT_CTRL)
        begin
            // an enable written while the fault is latched is dropped
            out_en_reg <= bus_i.wdata[NUM_OUT-1:0] & ~term_fault_i
                & ~fault_reg;
        end
        else
        begin
            out_en_reg <= out_en_reg & ~term_fault_i;
        end
    end

    //------------------------------------------------------------------
    // channel option and instrument mode map
    //------------------------------------------------------------------
    logic [3:0] analog_map;
    logic [3:0] marker_map;

    always_comb
    begin
        analog_map = 4'hF;
        marker_map = 4'h0;
        case (fpi_opt_t'(sys_ctrl_reg[SC_OPT_LSB +: 2]))
            FPI_OPT_1CH:
            begin
                analog_map = 4'h1;
                marker_map = 4'hC;
            end
            FPI_OPT_2CH:
            begin
                case (fpi_mode_t'(sys_ctrl_reg[SC_MODE_LSB +: 2]))
                    FPI_MODE_DUAL:
                    begin
                        analog_map = 4'h9;
                    end
                    FPI_MODE_DUAL_MRK:
                    begin
                        analog_map = 4'h3;
                        marker_map = 4'hC;
                    end
                    default:
                    begin
                        analog_map = 4'hF;
                    end
                endcase
            end
            default:
            begin
                analog_map = 4'hF;
            end
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_out
            always_ff @(posedge ref_clk_i)
            begin
                if (reset_i)
                begin
                    out_led_o[gi] <= FPI_LED_OFF;
                    amp_power_o[gi] <= 1'b0;
                    analog_en_o[gi] <= 1'b0;
                    marker_en_o[gi] <= 1'b0;
                end
                else
                begin
                    analog_en_o[gi] <= analog_map[gi % 4];
                    marker_en_o[gi] <= marker_map[gi % 4];
                    if (fault_reg[gi] || term_fault_i[gi])
                    begin
                        out_led_o[gi] <= FPI_LED_RED;
                        amp_power_o[gi] <= 1'b0;
                    end
                    else if (out_en_reg[gi])
                    begin
                        out_led_o[gi] <= FPI_LED_GREEN;
                        amp_power_o[gi] <= 1'b1;
                    end
                    else
                    begin
                        out_led_o[gi] <= FPI_LED_OFF;
                        amp_power_o[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // trigger and event input indicators
    //------------------------------------------------------------------
    // forced triggers never reach this logic, only pin edges do
    fpi_pin_t pin [2];
    logic [1:0] ext_sel;
    logic [1:0] prev_reg;
    logic [1:0] red_reg;
    logic [31:0] lit_cnt_reg [2];
    fpi_led_t led_next [2];

    assign pin[0] = trig_pin_i;
    assign pin[1] = event_pin_i;
    assign ext_sel[0] = trig_cfg_reg[TC_TRIG_EXT];
    assign ext_sel[1] = trig_cfg_reg[TC_EVT_EXT];

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_in
            logic rise;
            logic fall;
            logic hit;
            assign rise = pin[gi].level && !prev_reg[gi];
            assign fall = !pin[gi].level && prev_reg[gi];
            // gated: gate activation is the same edge as polarity
            assign hit = ext_sel[gi] && (
                (pol == FPI_POL_RISE && rise) ||
                (pol == FPI_POL_FALL && fall) ||
                (pol == FPI_POL_EITHER && !gated && (rise || fall))
            );

            always_ff @(posedge ref_clk_i)
            begin
                if (reset_i)
                begin
                    prev_reg[gi] <= 1'b0;
                    lit_cnt_reg[gi] <= '0;
                    red_reg[gi] <= 1'b0;
                end
                else
                begin
                    prev_reg[gi] <= pin[gi].level;
                    if (!ext_sel[gi])
                    begin
                        lit_cnt_reg[gi] <= '0;
                    end
                    else if (hit)
                    begin
                        lit_cnt_reg[gi] <= 32'(LIT_CYC);
                        red_reg[gi] <= sync_mode
                            && pin[gi].violation;
                    end
                    else if (lit_cnt_reg[gi] != '0)
                    begin
                        lit_cnt_reg[gi] <= lit_cnt_reg[gi] - 32'd1;
                    end
                end
            end

            always_comb
            begin
                if (lit_cnt_reg[gi] == '0 || !ext_sel[gi])
                begin
                    led_next[gi] = FPI_LED_OFF;
                end
                else if (red_reg[gi])
                begin
                    led_next[gi] = FPI_LED_RED;
                end
                else
                begin
                    led_next[gi] = FPI_LED_GREEN;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            trig_led_o <= FPI_LED_OFF;
            event_led_o <= FPI_LED_OFF;
        end
        else
        begin
            trig_led_o <= led_next[0];
            event_led_o <= led_next[1];
        end
    end

    //------------------------------------------------------------------
    // access and fail indicators
    //------------------------------------------------------------------
    logic [39:0] fail_cnt_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            fail_cnt_reg <= 40'(FAIL_CYC);
            fail_led_o <= 1'b1;
        end
        else
        begin
            if (fail_cnt_reg != '0)
            begin
                fail_cnt_reg <= fail_cnt_reg - 40'd1;
            end
            fail_led_o <= (fail_cnt_reg > 40'd1)
                || sys_ctrl_reg[SC_SELFTEST_ERR];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            access_led_o <= 1'b0;
        end
        else
        begin
            access_led_o <= bus_i.wr || bus_i.rd;
        end
    end

    //------------------------------------------------------------------
    // read data, one cycle after the strobe
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (!bus_i.rd)
        begin
            rdata_o <= 8'h00;
        end
        else if (bus_i.addr == ADDR_TRIG_CFG)
        begin
            rdata_o <= trig_cfg_reg;
        end
        else if (bus_i.addr == ADDR_OUT_CTRL)
        begin
            rdata_o <= 8'(out_en_reg);
        end
        else if (bus_i.addr == ADDR_SYS_CTRL)
        begin
            rdata_o <= {2'b00, sys_ctrl_reg};
        end
        else if (bus_i.addr == ADDR_STATUS)
        begin
            rdata_o <= 8'(fault_reg);
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

endmodule : fpi_indicators

// ---- verif/fpi_indicators_monitor.sv ----
// assertion checker for the front-panel indicator block
`timescale 1ns/1ps
module fpi_indicators_monitor #(
    parameter longint LIT_CYC = 20
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire fpi_pkg::fpi_bus_t bus_i,
    input wire fpi_pkg::fpi_pin_t trig_pin_i,
    input wire fpi_pkg::fpi_pin_t event_pin_i,
    input wire logic [3:0] term_fault_i,
    input wire fpi_pkg::fpi_led_t trig_led_o,
    input wire fpi_pkg::fpi_led_t event_led_o,
    input wire fpi_pkg::fpi_led_t [3:0] out_led_o,
    input wire logic [3:0] amp_power_o,
    input wire logic [3:0] analog_en_o,
    input wire logic [3:0] marker_en_o,
    input wire logic access_led_o,
    input wire logic fail_led_o
);
    import fpi_pkg::*;

    int since_reg;
    logic [3:0] trig_hist_reg;
    logic [3:0] viol_hist_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    // edge history is four deep to tolerate the sampling stages
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            since_reg <= 0;
            trig_hist_reg <= 4'h0;
            viol_hist_reg <= 4'h0;
        end
        else
        begin
            since_reg <= $changed(trig_pin_i.level) ? 0 : since_reg + 1;
            trig_hist_reg <= {trig_hist_reg[2:0], $changed(trig_pin_i.level)};
            viol_hist_reg <= {viol_hist_reg[2:0],
                $changed(event_pin_i.level) && event_pin_i.violation};
        end
    end

    property p_access;
        1'b1 |=> access_led_o == $past(bus_i.wr || bus_i.rd);
    endproperty
    a_access: assert property (p_access)
        else $error("access indicator does not follow bus activity");

    property p_fault;
        term_fault_i[1] |=> out_led_o[1] == FPI_LED_RED && !amp_power_o[1];
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault did not give red with amplifier off");

    property p_amp;
        amp_power_o[1] == (out_led_o[1] == FPI_LED_GREEN);
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplifier powered while output not enabled");

    property p_map;
        marker_en_o != 4'h0 |-> marker_en_o == 4'hC && analog_en_o[0];
    endproperty
    a_map: assert property (p_map)
        else $error("markers on wrong outputs");

    property p_trig_onset;
        trig_led_o != FPI_LED_OFF && $past(trig_led_o) == FPI_LED_OFF
            |-> trig_hist_reg != 4'h0;
    endproperty
    a_trig_onset: assert property (p_trig_onset)
        else $error("trigger indicator lit without an input edge");

    property p_lit_bound;
        trig_led_o != FPI_LED_OFF |-> since_reg <= LIT_CYC + 3;
    endproperty
    a_lit_bound: assert property (p_lit_bound)
        else $error("trigger indicator lit too long after last edge");

    property p_fail_boot;
        $fell(reset_i) |-> fail_led_o [*8];
    endproperty
    a_fail_boot: assert property (p_fail_boot)
        else $error("fail indicator not held after power-up");

    property p_event_red;
        event_led_o == FPI_LED_RED && $past(event_led_o) != FPI_LED_RED
            |-> viol_hist_reg != 4'h0;
    endproperty
    a_event_red: assert property (p_event_red)
        else $error("event indicator red without a violating edge");
endmodule : fpi_indicators_monitor

bind fpi_indicators fpi_indicators_monitor #(.LIT_CYC(LIT_CYC))
    i_fpi_indicators_monitor (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .trig_pin_i(trig_pin_i), .event_pin_i(event_pin_i),
    .term_fault_i(term_fault_i), .trig_led_o(trig_led_o),
    .event_led_o(event_led_o), .out_led_o(out_led_o),
    .amp_power_o(amp_power_o), .analog_en_o(analog_en_o),
    .marker_en_o(marker_en_o), .access_led_o(access_led_o),
    .fail_led_o(fail_led_o));

// ---- verif/fpi_ext_source.sv ----
// model of the external trigger and event sources
`timescale 1ns/1ps
module fpi_ext_source (
    input wire logic ref_clk_i,
    input wire logic [1:0] level_i,
    input wire logic [1:0] viol_i,
    output fpi_pkg::fpi_pin_t trig_o,
    output fpi_pkg::fpi_pin_t event_o
);
    import fpi_pkg::*;

    // a violation only exists in the cycle where the level moves
    always_ff @(posedge ref_clk_i)
    begin
        trig_o <= '{level_i[0], viol_i[0] && level_i[0] != trig_o.level};
        event_o <= '{level_i[1], viol_i[1] && level_i[1] != event_o.level};
    end
endmodule : fpi_ext_source

// ---- verif/tb_fpi_indicators.sv ----
// self-checking testbench for the front-panel indicator block
`timescale 1ns/1ps
module tb_fpi_indicators;
    import fpi_pkg::*;

    localparam int LIT = 20;
    localparam logic [7:0] LED_G = 8'h01;
    localparam logic [7:0] LED_R = 8'h02;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    fpi_bus_t bus_v = '0;
    logic [1:0] level_v = 2'b00;
    logic [1:0] viol_v = 2'b00;
    logic [3:0] fault_v = 4'h0;
    fpi_pin_t trig_w;
    fpi_pin_t event_w;
    logic [7:0] rdata_w;
    fpi_led_t trig_led_w;
    fpi_led_t event_led_w;
    fpi_led_t [3:0] out_led_w;
    logic [3:0] amp_w;
    logic [3:0] analog_w;
    logic [3:0] marker_w;
    logic access_w;
    logic fail_w;
    int fails = 0;
    int check_count = 0;
    logic [3:0] cfgs [5] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'h2};

    fpi_ext_source i_fpi_ext_source (.ref_clk_i(ref_clk_i),
        .level_i(level_v), .viol_i(viol_v), .trig_o(trig_w),
        .event_o(event_w));
    fpi_indicators #(.LIT_CYC(LIT), .FAIL_CYC(50)) i_fpi_indicators (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_v),
        .rdata_o(rdata_w), .trig_pin_i(trig_w), .event_pin_i(event_w),
        .term_fault_i(fault_v), .trig_led_o(trig_led_w),
        .event_led_o(event_led_w), .out_led_o(out_led_w),
        .amp_power_o(amp_w), .analog_en_o(analog_w),
        .marker_en_o(marker_w), .access_led_o(access_w),
        .fail_led_o(fail_w));

    initial
    begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] map_exp(input logic [3:0] c);
        case (c)
            4'h0: return 8'hC1;
            4'h1: return 8'h09;
            4'h5: return 8'hC3;
            default: return 8'h0F;
        endcase
    endfunction : map_exp

    task automatic wait_s(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wait_s

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus_v <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk_i);
        bus_v <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        bus_v <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk_i);
        bus_v <= '0;
        #1;
        chk(rdata_w, exp);
        chk({7'h00, access_w}, 8'h01);
    endtask : rd

    // pins move one edge after the request, violation for one cycle
    task automatic pin(input logic [1:0] lvl, input logic [1:0] v);
        @(posedge ref_clk_i);
        level_v <= lvl;
        viol_v <= v;
        @(posedge ref_clk_i);
        viol_v <= 2'b00;
    endtask : pin

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h03f776fb));
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        wait_s(2);
        chk({7'h00, fail_w}, 8'h01);
        rd(ADDR_TRIG_CFG, TRIG_CFG_RESET);
        rd(4'hF, 8'h00);
        wr(ADDR_TRIG_CFG, 8'h0C);
        pin(2'b01, 2'b00);
        wait_s(4);
        chk(8'(trig_led_w), LED_G);
        wait_s(LIT + 8);
        chk(8'(trig_led_w), 8'h00);
        pin(2'b00, 2'b00);
        wait_s(4);
        chk(8'(trig_led_w), 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk_i);
            level_v[0] <= (i % 10) < 5;
            #1;
            if (i > 5)
                chk(8'(trig_led_w), LED_G);
        end
        wr(ADDR_TRIG_CFG, 8'h2C);
        pin(2'b10, 2'b10);
        wait_s(4);
        chk(8'(event_led_w), LED_R);
        pin(2'b00, 2'b00);
        pin(2'b10, 2'b00);
        wait_s(4);
        chk(8'(event_led_w), LED_G);
        wr(ADDR_TRIG_CFG, 8'h0C);
        pin(2'b00, 2'b00);
        pin(2'b10, 2'b10);
        wait_s(4);
        chk(8'(event_led_w), LED_G);
        wr(ADDR_TRIG_CFG, 8'h16);
        rd(ADDR_TRIG_CFG, 8'h14);
        wr(ADDR_TRIG_CFG, 8'h15);
        wait_s(LIT + 8);
        pin(2'b01, 2'b00);
        wait_s(4);
        chk(8'(trig_led_w), 8'h00);
        pin(2'b00, 2'b00);
        wait_s(4);
        chk(8'(trig_led_w), LED_G);
        wr(ADDR_TRIG_CFG, 8'h08);
        wait_s(4);
        chk(8'(trig_led_w), 8'h00);
        pin(2'b01, 2'b00);
        wait_s(4);
        chk(8'(trig_led_w), 8'h00);
        wr(ADDR_OUT_CTRL, 8'h0F);
        wait_s(2);
        chk(8'(out_led_w), 8'h00);
        wr(ADDR_SYS_CTRL, 8'h10);
        wr(ADDR_OUT_CTRL, 8'h0F);
        wait_s(2);
        chk(8'(out_led_w), 8'h55);
        chk({4'h0, amp_w}, 8'h0F);
        @(posedge ref_clk_i);
        fault_v <= 4'h2;
        @(posedge ref_clk_i);
        fault_v <= 4'h0;
        wait_s(4);
        chk(8'(out_led_w), 8'h59);
        chk({4'h0, amp_w}, 8'h0D);
        // enable before the clear must not bring the output back
        wr(ADDR_OUT_CTRL, 8'h0F);
        wr(ADDR_STATUS, 8'h02);
        wait_s(2);
        chk(8'(out_led_w), 8'h51);
        wr(ADDR_OUT_CTRL, 8'h0F);
        wait_s(2);
        chk(8'(out_led_w), 8'h55);
        foreach (cfgs[k])
        begin
            wr(ADDR_SYS_CTRL, {4'h1, cfgs[k]});
            wait_s(2);
            chk({marker_w, analog_w}, map_exp(cfgs[k]));
        end
        chk({7'h00, fail_w}, 8'h00);
        wr(ADDR_SYS_CTRL, 8'h30);
        wait_s(2);
        chk({7'h00, fail_w}, 8'h01);
        wr(ADDR_SYS_CTRL, 8'h10);
        repeat (150)
        begin
            wr(ADDR_TRIG_CFG, {6'h0B, 2'($urandom_range(2))});
            pin(2'($urandom), 2'($urandom));
            rd(ADDR_STATUS, 8'h00);
            wait_s(int'($urandom_range(25)));
        end
        pin(2'b00, 2'b00);
        wait_s(LIT + 8);
        chk({8'(trig_led_w) | 8'(event_led_w)}, 8'h00);
        print_verdict();
    end

    initial
    begin
        wait_s(20000);
        fails++;
        print_verdict();
    end
endmodule : tb_fpi_indicators
